// file: pxr_regs.sv
`timescale 1ns/1ns
module pxr_regs
    import pxr_pkg::*;
#(
    parameter logic [7:0] PART_ID = PXR_ID_DEFAULT
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // Register port from the serial command decoder.
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_rd_i,
    output logic [7:0]       reg_rdata_o,
    output logic             reg_rvalid_o,
    // Sequencer and converter events.
    input  wire logic        drive_reduce_bit_i,
    input  wire logic        prox_accum_start_i,
    input  wire logic        prox_done_i,
    input  wire logic [15:0] prox_data_i,
    input  wire logic        prox_saturated_i,
    input  wire logic        light_chan0_done_i,
    input  wire logic [15:0] light_chan0_data_i,
    input  wire logic        light_chan1_done_i,
    input  wire logic [15:0] light_chan1_data_i,
    input  wire logic        proximity_irq_i,
    input  wire logic        light_irq_i,
    // Analog controls and LED drive.
    output logic             led_drive_pin_o,
    output logic             prox_pulses_done_o,
    output logic [9:0]       led_current_dma_o,
    output logic [1:0]       photodiode_select_o,
    output logic             photodiode_valid_o,
    output logic [3:0]       proximity_gain_x_o,
    output logic [6:0]       light_gain_x_o
);

    // ----------------------------------------------------------------
    // Lookup functions
    // ----------------------------------------------------------------

    // LED current in tenths of a milliampere.
    function automatic logic [9:0] led_current(input logic [1:0] sel, input logic reduce);
        logic [9:0] ma;
        ma = 10'h000;
        case ({reduce, sel})
            3'h0:    ma = 10'h3E8;
            3'h1:    ma = 10'h1F4;
            3'h2:    ma = 10'h0FA;
            3'h3:    ma = 10'h07D;
            3'h4:    ma = 10'h06F;
            3'h5:    ma = 10'h038;
            3'h6:    ma = 10'h01C;
            default: ma = 10'h00E;
        endcase
        return ma;
    endfunction

    // Light gain multiplier.
    function automatic logic [6:0] light_gain(input logic [1:0] code);
        logic [6:0] g;
        g = 7'h00;
        case (code)
            2'h0:    g = 7'h01;
            2'h1:    g = 7'h08;
            2'h2:    g = 7'h10;
            default: g = 7'h78;
        endcase
        return g;
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0]   pulse_count;
    logic [7:0]   next_pulse_count;
    pxr_ctrl_t    ctrl;
    pxr_ctrl_t    next_ctrl;
    pxr_results_t res;
    pxr_results_t next_res;
    logic [7:0]   shadow_ch0;
    logic [7:0]   next_shadow_ch0;
    logic [7:0]   shadow_ch1;
    logic [7:0]   next_shadow_ch1;
    logic [7:0]   shadow_prx;
    logic [7:0]   next_shadow_prx;
    logic         prox_valid;
    logic         next_prox_valid;
    logic         ch0_seen;
    logic         next_ch0_seen;
    logic         ch1_seen;
    logic         next_ch1_seen;
    logic         light_valid;
    logic         next_light_valid;
    logic [2:0]   flags;
    logic [2:0]   next_flags;
    logic [7:0]   status_byte;
    logic [7:0]   next_rdata;
    logic [9:0]   next_current;
    logic [3:0]   next_proximity_gain;
    logic [6:0]   next_lgain;

    // ----------------------------------------------------------------
    // Writable control registers
    // ----------------------------------------------------------------

    // Only the pulse count and control registers accept writes.
    always_comb begin
        next_pulse_count = pulse_count;
        next_ctrl        = ctrl;
        if (reg_wr_i) begin
            if (reg_addr_i == PXR_OFS_PULSE) begin
                next_pulse_count = reg_wdata_i;  // R1
            end
            if (reg_addr_i == PXR_OFS_CTRL) begin
                next_ctrl = pxr_ctrl_t'(reg_wdata_i);  // R4 R5 R6
            end
        end
    end

    // Derived analog settings.
    always_comb begin
        next_current = led_current(ctrl.led_current_select, drive_reduce_bit_i);  // R4
        next_proximity_gain   = 4'(4'h1 << ctrl.proximity_gain);  // R6
        next_lgain   = light_gain(ctrl.light_gain);  // R6
    end

    // Control and derived setting registers.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pulse_count         <= PXR_RST_PULSE;
            ctrl                <= pxr_ctrl_t'(PXR_RST_CTRL);
            led_current_dma_o   <= 10'h3E8;
            proximity_gain_x_o  <= 4'h1;
            light_gain_x_o      <= 7'h01;
            photodiode_select_o <= 2'h0;
            photodiode_valid_o  <= 1'b0;
        end else begin
            pulse_count         <= next_pulse_count;
            ctrl                <= next_ctrl;
            led_current_dma_o   <= next_current;
            proximity_gain_x_o  <= next_proximity_gain;
            light_gain_x_o      <= next_lgain;
            photodiode_select_o <= ctrl.photodiode_select;
            photodiode_valid_o  <= (ctrl.photodiode_select == PXR_DIODE_CH1);  // R5
        end
    end

    // ----------------------------------------------------------------
    // Results and status
    // ----------------------------------------------------------------

    // Capture finished conversions and track data-valid state.
    always_comb begin
        next_res         = res;
        next_prox_valid  = prox_valid;
        next_ch0_seen    = ch0_seen;
        next_ch1_seen    = ch1_seen;
        next_light_valid = light_valid;
        next_flags       = {prox_saturated_i, proximity_irq_i, light_irq_i};  // R8
        if (prox_done_i) begin
            next_res.prox   = prox_data_i;
            next_prox_valid = 1'b1;  // R9
        end
        if (light_chan0_done_i) begin
            next_res.chan0 = light_chan0_data_i;
            next_ch0_seen  = 1'b1;
        end
        if (light_chan1_done_i) begin
            next_res.chan1 = light_chan1_data_i;
            next_ch1_seen  = 1'b1;
        end
        if (next_ch0_seen && next_ch1_seen) begin
            next_light_valid = 1'b1;  // R10
        end
    end

    // Result and status registers.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            res         <= '0;
            prox_valid  <= 1'b0;
            ch0_seen    <= 1'b0;
            ch1_seen    <= 1'b0;
            light_valid <= 1'b0;
            flags       <= 3'h0;
        end else begin
            res         <= next_res;
            prox_valid  <= next_prox_valid;
            ch0_seen    <= next_ch0_seen;
            ch1_seen    <= next_ch1_seen;
            light_valid <= next_light_valid;
            flags       <= next_flags;
        end
    end

    // Status byte with reserved bits reading zero.
    always_comb begin
        status_byte                = 8'h00;
        status_byte[PXR_ST_PROXIMITY_SATURATED_FLAG]   = flags[2];  // R8
        status_byte[PXR_ST_PIRQ]   = flags[1];  // R8
        status_byte[PXR_ST_LIRQ]   = flags[0];  // R8
        status_byte[PXR_ST_PROXIMITY_RESULT_READY] = prox_valid;  // R9
        status_byte[PXR_ST_LVALID] = light_valid;  // R10
    end

    // ----------------------------------------------------------------
    // Read path with high-byte shadows
    // ----------------------------------------------------------------

    // A low-byte read snapshots the matching high byte, so later
    // conversions cannot tear the pair.
    always_comb begin
        next_rdata      = PXR_RST_BYTE;
        next_shadow_ch0 = shadow_ch0;
        next_shadow_ch1 = shadow_ch1;
        next_shadow_prx = shadow_prx;
        if (reg_rd_i) begin
            case (reg_addr_i)
                PXR_OFS_PULSE:  next_rdata = pulse_count;
                PXR_OFS_CTRL:   next_rdata = 8'(ctrl);
                PXR_OFS_ID:     next_rdata = PART_ID;  // R7
                PXR_OFS_STATUS: next_rdata = status_byte;  // R8
                PXR_OFS_CH0_LO: begin
                    next_rdata      = res.chan0[7:0];  // R11
                    next_shadow_ch0 = res.chan0[15:8];  // R12
                end
                PXR_OFS_CH0_HI: next_rdata = shadow_ch0;  // R13
                PXR_OFS_CH1_LO: begin
                    next_rdata      = res.chan1[7:0];  // R11
                    next_shadow_ch1 = res.chan1[15:8];  // R12
                end
                PXR_OFS_CH1_HI: next_rdata = shadow_ch1;  // R13
                PXR_OFS_PRX_LO: begin
                    next_rdata      = res.prox[7:0];  // R14
                    next_shadow_prx = res.prox[15:8];  // R14
                end
                PXR_OFS_PRX_HI: next_rdata = shadow_prx;  // R14
                default:        next_rdata = PXR_RST_BYTE;
            endcase
        end
    end

    // Read data, shadow registers and read strobe.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            reg_rdata_o  <= PXR_RST_BYTE;
            reg_rvalid_o <= 1'b0;
            shadow_ch0   <= PXR_RST_BYTE;
            shadow_ch1   <= PXR_RST_BYTE;
            shadow_prx   <= PXR_RST_BYTE;
        end else begin
            reg_rdata_o  <= next_rdata;
            reg_rvalid_o <= reg_rd_i;
            shadow_ch0   <= next_shadow_ch0;
            shadow_ch1   <= next_shadow_ch1;
            shadow_prx   <= next_shadow_prx;
        end
    end

    // ----------------------------------------------------------------
    // LED pulse train
    // ----------------------------------------------------------------

    // Emits the programmed number of pulses each accumulation.
    pxr_led_pulser #(
        .PERIOD_CYC (PXR_PULSE_PERIOD_CYC),
        .HIGH_CYC   (PXR_PULSE_HIGH_CYC)
    ) u_pulser (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .start_i   (prox_accum_start_i),
        .count_i   (pulse_count),
        .pin_o     (led_drive_pin_o),
        .done_o    (prox_pulses_done_o)
    );

endmodule

// file: pxr_pkg.sv
// Contract
// (R1) 8-bit pulse count register at 0x0E.
// (R2) LED pulses repeat at 62.5 kHz.
// (R3) Host should use 100 mA, 8 pulses.
// (R4) Bits 7:6 pick current; reduce bit divides by 9.
// (R5) Diode select bits 5:4; only 10 valid.
// (R6) Proximity gain bits 3:2, light gain 1:0.
// (R7) Read-only identification register at 0x12.
// (R8) Status 0x13: saturation, proximity, light interrupts.
// (R9) Status bit 1: proximity data valid.
// (R10) Status bit 0: both light channels valid.
// (R11) Light results at 0x14 to 0x17, low first.
// (R12) Low-byte read latches high byte into shadow.
// (R13) High byte matches low despite later conversions.
// (R14) Proximity result at 0x18/0x19, same shadowing.
// (R15) Host reads results as two-byte auto-increment reads.
package pxr_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] PXR_OFS_PULSE  = 8'h0E;
    localparam logic [7:0] PXR_OFS_CTRL   = 8'h0F;
    localparam logic [7:0] PXR_OFS_ID     = 8'h12;
    localparam logic [7:0] PXR_OFS_STATUS = 8'h13;
    localparam logic [7:0] PXR_OFS_CH0_LO = 8'h14;
    localparam logic [7:0] PXR_OFS_CH0_HI = 8'h15;
    localparam logic [7:0] PXR_OFS_CH1_LO = 8'h16;
    localparam logic [7:0] PXR_OFS_CH1_HI = 8'h17;
    localparam logic [7:0] PXR_OFS_PRX_LO = 8'h18;
    localparam logic [7:0] PXR_OFS_PRX_HI = 8'h19;

    // ----------------------------------------------------------------
    // Reset values and fixed codes
    // ----------------------------------------------------------------
    localparam logic [7:0] PXR_RST_PULSE  = 8'h00;
    localparam logic [7:0] PXR_RST_CTRL   = 8'h00;
    localparam logic [7:0] PXR_RST_BYTE   = 8'h00;
    localparam logic [7:0] PXR_ID_DEFAULT = 8'h5A;  // Arbitrary value, no part meaning.
    localparam logic [1:0] PXR_DIODE_CH1  = 2'h2;

    // ----------------------------------------------------------------
    // Status bit positions
    // ----------------------------------------------------------------
    localparam int PXR_ST_PROXIMITY_SATURATED_FLAG   = 6;
    localparam int PXR_ST_PIRQ   = 5;
    localparam int PXR_ST_LIRQ   = 4;
    localparam int PXR_ST_PROXIMITY_RESULT_READY = 1;
    localparam int PXR_ST_LVALID = 0;

    // ----------------------------------------------------------------
    // Timing: LED pulse rate of 62.5 kHz on a 50 MHz clock
    // ----------------------------------------------------------------
    localparam int PXR_CLK_PERIOD_PS   = 20000;
    localparam int PXR_PULSE_PERIOD_PS = 16000000;
    localparam int PXR_PULSE_PERIOD_CYC = PXR_PULSE_PERIOD_PS / PXR_CLK_PERIOD_PS;
    localparam int PXR_PULSE_HIGH_CYC   = PXR_PULSE_PERIOD_CYC / 2;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] led_current_select;
        logic [1:0] photodiode_select;
        logic [1:0] proximity_gain;
        logic [1:0] light_gain;
    } pxr_ctrl_t;

    typedef struct packed {
        logic [15:0] chan0;
        logic [15:0] chan1;
        logic [15:0] prox;
    } pxr_results_t;

    typedef enum logic [1:0] {
        PXR_IDLE = 2'b00,
        PXR_HIGH = 2'b01,
        PXR_LOW  = 2'b11
    } pxr_pulse_state_t;

endpackage

// file: pxr_led_pulser.sv
`timescale 1ns/1ns
module pxr_led_pulser
    import pxr_pkg::*;
#(
    parameter int unsigned PERIOD_CYC = PXR_PULSE_PERIOD_CYC,
    parameter int unsigned HIGH_CYC   = PXR_PULSE_HIGH_CYC
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic [7:0] count_i,
    output logic            pin_o,
    output logic            done_o
);

    pxr_pulse_state_t state_q;
    pxr_pulse_state_t next_state;
    logic [15:0]      cyc_q;
    logic [15:0]      next_cyc;
    logic [7:0]       left_q;
    logic [7:0]       next_left;
    logic             next_pin;
    logic             next_done;

    // Pulse train sequencer: count_i pulses, each one period long.
    always_comb begin
        next_state = state_q;
        next_cyc   = cyc_q;
        next_left  = left_q;
        next_done  = 1'b0;
        case (state_q)
            PXR_IDLE: begin
                if (start_i) begin
                    if (count_i != 8'h00) begin
                        next_state = PXR_HIGH;  // R1
                        next_cyc   = 16'h0000;
                        next_left  = count_i;
                    end else begin
                        next_done = 1'b1;
                    end
                end
            end
            PXR_HIGH: begin
                if (cyc_q == 16'(HIGH_CYC - 1)) begin
                    next_state = PXR_LOW;
                    next_cyc   = 16'h0000;
                end else begin
                    next_cyc = cyc_q + 16'h0001;
                end
            end
            PXR_LOW: begin
                if (cyc_q == 16'(PERIOD_CYC - HIGH_CYC - 1)) begin  // R2
                    next_cyc = 16'h0000;
                    if (left_q == 8'h01) begin
                        next_state = PXR_IDLE;
                        next_left  = 8'h00;
                        next_done  = 1'b1;
                    end else begin
                        next_state = PXR_HIGH;
                        next_left  = left_q - 8'h01;  // R1
                    end
                end else begin
                    next_cyc = cyc_q + 16'h0001;
                end
            end
            default: begin
                next_state = PXR_IDLE;
            end
        endcase
        next_pin = (next_state == PXR_HIGH);
    end

    // State registers.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q <= PXR_IDLE;
            cyc_q   <= 16'h0000;
            left_q  <= 8'h00;
            pin_o   <= 1'b0;
            done_o  <= 1'b0;
        end else begin
            state_q <= next_state;
            cyc_q   <= next_cyc;
            left_q  <= next_left;
            pin_o   <= next_pin;
            done_o  <= next_done;
        end
    end

endmodule

// file: pxr_regs_monitor.sv
`timescale 1ns/1ns
module pxr_regs_monitor
    import pxr_pkg::*;
#(
    parameter logic [7:0] PART_ID = PXR_ID_DEFAULT
) (
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       reg_rvalid_o,
    input wire logic       prox_done_i,
    input wire logic       led_drive_pin_o,
    input wire logic       prox_pulses_done_o,
    input wire logic [1:0] photodiode_select_o,
    input wire logic       photodiode_valid_o,
    input wire logic [3:0] proximity_gain_x_o
);
    // ----------------------------------------------------------------
    // Helper logic
    // ----------------------------------------------------------------
    int unsigned hi_cnt;
    int unsigned next_hi_cnt;

    // Counts the cycles the LED pin has been high in the current pulse.
    always_comb begin
        next_hi_cnt = (rst_i || !led_drive_pin_o) ? 0 : hi_cnt + 1;
    end

    // Registers the high-phase count.
    always_ff @(posedge ref_clk_i) begin
        hi_cnt <= next_hi_cnt;
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking mon_cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_read_answered: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read strobe got no answer");
    a_no_stray_answer: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("answer without a read");
    a_idle_rdata_zero: assert property (!reg_rvalid_o |-> reg_rdata_o == 8'h00)
        else $error("read data not zero while idle");
    a_id_fixed: assert property (reg_rd_i && reg_addr_i == PXR_OFS_ID |=> reg_rdata_o == PART_ID)
        else $error("identification value wrong");
    a_pulse_readback: assert property ((reg_wr_i && reg_addr_i == PXR_OFS_PULSE) ##1
        (reg_rd_i && !reg_wr_i && reg_addr_i == PXR_OFS_PULSE) |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("pulse count readback wrong");
    a_gain_follows: assert property ((reg_wr_i && reg_addr_i == PXR_OFS_CTRL) ##1 !reg_wr_i
        |=> proximity_gain_x_o == (4'h1 << $past(reg_wdata_i[3:2], 2)))
        else $error("proximity gain output wrong");
    a_diode_valid: assert property (photodiode_valid_o == (photodiode_select_o == PXR_DIODE_CH1))
        else $error("diode valid flag wrong");
    a_prox_valid_set: assert property (reg_rd_i && reg_addr_i == PXR_OFS_STATUS && $past(prox_done_i)
        && !$past(rst_i) |=> reg_rdata_o[PXR_ST_PROXIMITY_RESULT_READY])
        else $error("proximity valid flag not set");
    a_pulse_width: assert property ($fell(led_drive_pin_o) && !$past(rst_i) |-> hi_cnt == 400)
        else $error("LED pulse high time wrong");

    c_pair_read: cover property (reg_rd_i && reg_addr_i == PXR_OFS_PRX_LO ##1 reg_rd_i && reg_addr_i == PXR_OFS_PRX_HI);
    c_led_rise: cover property ($rose(led_drive_pin_o));
    c_train_done: cover property (prox_pulses_done_o);
endmodule

bind pxr_regs pxr_regs_monitor #(.PART_ID(PART_ID)) u_mon (.*);

// file: pxr_front_model.sv
`timescale 1ns/1ns
module pxr_front_model
    import pxr_pkg::*;
(
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire logic [2:0]   go_i,
    input  wire pxr_results_t res_i,
    output logic [2:0]        done_o,
    output pxr_results_t      res_o
);
    pxr_results_t held;

    // Finishes a conversion one cycle after a request and keeps its result.
    always_ff @(posedge ref_clk_i) begin
        done_o <= rst_i ? 3'h0 : go_i;
        if (rst_i) begin
            held <= '0;
        end else if (|go_i) begin
            held <= res_i;
        end
    end

    // Result lines carry the inverse outside a done pulse, so late sampling shows.
    assign res_o = (|done_o) ? held : ~held;
endmodule

// file: tb.sv
`timescale 1ns/1ns
module tb;
    import pxr_pkg::*;
    logic ref_clk_i, rst_i, wr, rd, red, start, sat, pirq, lirq, rvalid, led, pdone, dval;
    logic [7:0]   addr, wdata, rdata;
    logic [2:0]   go, done;
    pxr_results_t res, mres;
    logic [9:0]   cur;
    logic [1:0]   dsel;
    logic [3:0]   pg;
    logic [6:0]   lg;
    logic [15:0]  v;
    logic [7:0]   got [2];
    logic [9:0]   cur_t [8] = '{10'h3E8, 10'h1F4, 10'hFA, 10'h7D, 10'h6F, 10'h38, 10'h1C, 10'hE};
    logic [6:0]   lg_t [4] = '{7'h1, 7'h8, 7'h10, 7'h78};
    int num_errors = 0, num_checks = 0, cyc = 0, n, highs;

    pxr_regs u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .drive_reduce_bit_i(red), .prox_accum_start_i(start), .prox_done_i(done[2]),
        .prox_data_i(mres.prox), .prox_saturated_i(sat), .light_chan0_done_i(done[0]),
        .light_chan0_data_i(mres.chan0), .light_chan1_done_i(done[1]), .light_chan1_data_i(mres.chan1),
        .proximity_irq_i(pirq), .light_irq_i(lirq), .led_drive_pin_o(led), .prox_pulses_done_o(pdone),
        .led_current_dma_o(cur), .photodiode_select_o(dsel), .photodiode_valid_o(dval),
        .proximity_gain_x_o(pg), .light_gain_x_o(lg));
    pxr_front_model u_front (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .go_i(go), .res_i(res),
        .done_o(done), .res_o(mres));

    // Clock generator.
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    // Cuts a hung run short.
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            num_errors++;
            $display("CHECK FAILED t=%0t timeout", $time);
            tally_and_finish();
        end
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge ref_clk_i);
        wr <= 1'b0;
    endtask

    // Reads n bytes from consecutive offsets, one strobe per cycle.
    task automatic rd_reg(input logic [7:0] a, input int n);
        @(posedge ref_clk_i);
        rd <= 1'b1; addr <= a;
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk_i);
            if (i == n - 1) rd <= 1'b0; else addr <= a + 8'(i + 1);
            #1;
            chk({15'h0, rvalid}, 16'h1, "rvalid");
            got[i] = rdata;
        end
    endtask

    task automatic conv(input logic [2:0] g, input logic [15:0] d);
        @(posedge ref_clk_i);
        go <= g; res <= '{d, d, d};
        @(posedge ref_clk_i);
        go <= 3'h0;
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        rst_i = 1'b1; wr = 0; rd = 0; red = 0; start = 0; sat = 0; pirq = 0; lirq = 0;
        addr = 8'h00; wdata = 8'h00; go = 3'h0; res = '0;
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd_reg(PXR_OFS_PULSE, 2); chk({got[1], got[0]}, 16'h0, "reset pulse/ctrl");
        wr_reg(PXR_OFS_ID, 8'hFF);
        rd_reg(PXR_OFS_ID, 2); chk({got[1], got[0]}, {8'h00, PXR_ID_DEFAULT}, "id/status");
        rd_reg(8'h10, 1); chk(16'(got[0]), 16'h0, "unmapped");
        $display("test reset done");
        // Every drive and reduce combination, both gains set to the drive code, with the valid diode code.
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk_i);
            red <= i[2];
            wr_reg(PXR_OFS_CTRL, {i[1:0], PXR_DIODE_CH1, i[1:0], i[1:0]});
            @(posedge ref_clk_i); #1;
            chk(16'(cur), 16'(cur_t[i]), "current");
            chk({pg, 5'h0, lg}, {4'h1 << i[1:0], 5'h0, lg_t[i[1:0]]}, "gains");
            chk({dsel, 1'b0, dval}, {PXR_DIODE_CH1, 2'h1}, "diode");
            rd_reg(PXR_OFS_CTRL, 1); chk(16'(got[0]), {8'h0, i[1:0], PXR_DIODE_CH1, i[1:0], i[1:0]}, "ctrl");
        end
        for (int d = 0; d < 4; d += (d == 1) ? 2 : 1) begin
            wr_reg(PXR_OFS_CTRL, {2'h0, 2'(d), 4'h0});
            @(posedge ref_clk_i); #1;
            chk({dsel, 1'b0, dval}, {2'(d), 2'h0}, "reserved diode");
        end
        $display("test control done");
        // Shadow latching with a conversion between low and high reads.
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk_i);
            sat <= k[0]; pirq <= k[1]; lirq <= ~k[0];
            v = 16'hA1B2 + 16'(k);
            conv(3'h1 << k, v);
            rd_reg(PXR_OFS_STATUS, 1);
            chk(16'(got[0]), {9'h0, k[0], k[1], ~k[0], 2'h0, k == 2, k >= 1}, "status");
            rd_reg(PXR_OFS_CH0_LO + 8'(2 * k), 1); chk(16'(got[0]), 16'(v[7:0]), "low byte");
            conv(3'h1 << k, ~v);
            rd_reg(PXR_OFS_CH0_HI + 8'(2 * k), 1); chk(16'(got[0]), 16'(v[15:8]), "shadow");
            rd_reg(PXR_OFS_CH0_LO + 8'(2 * k), 2); chk({got[1], got[0]}, ~v, "pair read");
        end
        $display("test results done");
        // LED trains of 2 pulses and of none.
        for (int c = 2; c >= 0; c -= 2) begin
            // Write the count and read it back in the very next cycle.
            @(posedge ref_clk_i);
            wr <= 1'b1;
            addr <= PXR_OFS_PULSE;
            wdata <= 8'(c);
            @(posedge ref_clk_i);
            wr <= 1'b0;
            rd <= 1'b1;
            @(posedge ref_clk_i);
            rd <= 1'b0;
            #1;
            chk(16'(rdata), 16'(c), "pulse count");
            @(posedge ref_clk_i);
            start <= 1'b1;
            @(posedge ref_clk_i);
            start <= 1'b0;
            n = 0;
            highs = 0;
            // Look right after the start is taken, so a one-cycle done is not missed.
            #1;
            while (!pdone && n < 2000) begin
                highs += int'(led === 1'b1);
                @(posedge ref_clk_i);
                #1;
                n++;
            end
            chk(16'(n), 16'(800 * c), "train length");
            chk(16'(highs), 16'(400 * c), "high cycles");
        end
        $display("test led done");
        tally_and_finish();
    end
endmodule
